/* File: hw/rca_pkg.sv */
// constants and types for the calendar, alarm and countdown block
// Notes on behaviour
// [RULE_01] weekday is 3 bits, 0 Sunday up to 6 Saturday, 7 unused
// [RULE_02] year is four BCD digits in four nibbles, thousands in low two bits
// [RULE_03] February has 29 days in every year divisible by four
// [RULE_04] alarm flag sets when all unmasked alarm fields equal running counters
// [RULE_05] alarm flag holds until 0 written; 1 ignored; 0 ignored 1us after set
// [RULE_06] alarm pin pulled low only while alarm flag and its enable are 1
// [RULE_07] mask bit 3 at 0 compares the field, at 1 field is don't-care
// [RULE_08] writing run bit 1 starts countdown, writing 0 halts it
// [RULE_09] countdown flag sets at zero, holds until 0 written, same 1us lockout
// [RULE_10] countdown pin pulled low on event only when its enable is 1
// [RULE_11] level mode keeps pin low and flag set until flag written 0
// [RULE_12] level mode clears run bit at zero, unless started with flag set
// [RULE_13] periodic mode releases pin after a fixed interval; flag stays
// [RULE_14] periodic mode reloads preset after that interval and keeps counting
// [RULE_15] source select 00 4096Hz, 01 64Hz, 10 1Hz, 11 one per minute
// [RULE_16] two preset nibbles form the 8-bit start value, low nibble first
// [RULE_17] live count readable as low then high nibble while counting
// [RULE_18] writing either preset nibble loads the counter at once
// [RULE_19] preset nibbles keep their value until overwritten
// [RULE_20] counting begins at next falling source edge after the start write
// [RULE_21] after stop one more decrement may happen, and may raise an event
// [RULE_22] first counted period lasts zero to one source cycle
// [RULE_23] periodic pin low time is half a source period; with the minute source the pin releases at the next 1Hz rising edge
// [RULE_24] live count nibbles are read-only, writes ignored
// [RULE_25] bank select 00 bank 0, 01 bank 1, 10 bank 2, 11 bank 1
// [RULE_26] calendar counters are BCD, one digit per nibble
// [RULE_27] hour wrap advances weekday modulo seven and rolls date, month, year
package rca_pkg;
  localparam int CLK_NS = 8;
  localparam int FLAG_LOCK_NS = 1000;
  localparam int FLAG_LOCK_CYC = FLAG_LOCK_NS / CLK_NS;
  localparam logic [1:0] BANK_CAL = 2'h0;
  localparam logic [1:0] BANK_ALM = 2'h1;
  localparam logic [1:0] BANK_TMR = 2'h2;
  localparam logic [1:0] BANK_ALT = 2'h3;
  localparam logic [3:0] R_SEC_U = 4'h0;
  localparam logic [3:0] R_SEC_T = 4'h1;
  localparam logic [3:0] R_MIN_U = 4'h2;
  localparam logic [3:0] R_MIN_T = 4'h3;
  localparam logic [3:0] R_HOUR_U = 4'h4;
  localparam logic [3:0] R_HOUR_T = 4'h5;
  localparam logic [3:0] R_WDAY = 4'h6;
  localparam logic [3:0] R_DATE_U = 4'h7;
  localparam logic [3:0] R_DATE_T = 4'h8;
  localparam logic [3:0] R_MON_U = 4'h9;
  localparam logic [3:0] R_MON_T = 4'hA;
  localparam logic [3:0] R_YEAR_U = 4'hB;
  localparam logic [3:0] R_YEAR_T = 4'hC;
  localparam logic [3:0] R_YEAR_H = 4'hD;
  localparam logic [3:0] R_CTRL_E = 4'hE;
  localparam logic [3:0] R_CTRL_F = 4'hF;
  localparam logic [3:0] R_PRE_LO = 4'h4;
  localparam logic [3:0] R_PRE_HI = 4'h5;
  localparam logic [3:0] R_LIVE_LO = 4'h6;
  localparam logic [3:0] R_LIVE_HI = 4'h7;
  localparam logic [3:0] R_TSET = 4'h8;
  localparam int ALARM_REGS = 9;
  localparam int MASK_BIT = 3;
  localparam int FLAG_BIT = 1;
  localparam int IEN_BIT = 0;
  localparam int RUN_BIT = 3;
  localparam int MODE_BIT = 2;
  localparam logic [1:0] SRC_4096 = 2'h0;
  localparam logic [1:0] SRC_64 = 2'h1;
  localparam logic [1:0] SRC_1HZ = 2'h2;
  localparam logic [14:0] DIV_4096 = 15'h0007;
  localparam logic [14:0] DIV_64 = 15'h01FF;
  localparam logic [14:0] DIV_1HZ = 15'h7FFF;
  localparam logic [14:0] HALF_4096 = 15'h0003;
  localparam logic [14:0] HALF_64 = 15'h00FF;
  localparam logic [14:0] HALF_1HZ = 15'h3FFF;
  localparam logic [2:0] WDAY_LAST = 3'h6;
  localparam logic [3:0] DIG_ONE = 4'h1;
  localparam logic [3:0] DIG_TWO = 4'h2;
  localparam logic [3:0] DIG_NINE = 4'h9;
  typedef struct packed {
    logic selN;
    logic host_write_strobe_n;
    logic [3:0] addr;
    logic [3:0] data;
  } rca_host_type;
  typedef struct packed {
    logic [3:0] secU;
    logic [2:0] secT;
    logic [3:0] minU;
    logic [2:0] minT;
    logic [3:0] hourU;
    logic [1:0] hourT;
  } rca_clock_type;
  typedef enum logic [1:0] {TMR_IDLE, TMR_RUN, TMR_LAST, TMR_RETURN} rca_tmr_type;
endpackage

/* File: hw/rca_top.sv */
// calendar, alarm compare and countdown timer behind the 4-bit register port
module rca_top #(
  parameter int LOCK_CYC = rca_pkg::FLAG_LOCK_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire rca_pkg::rca_host_type host,
  input wire logic tick32k,
  input wire logic secTick,
  input wire logic minuteTick,
  input wire logic dayCarry,
  input wire rca_pkg::rca_clock_type clockNow,
  output logic [3:0] hostRdData,
  output logic alarmIrqPinN,
  output logic alarmIrqPinNOe,
  output logic countdownIrqPinN,
  output logic countdownIrqPinNOe
);
  import rca_pkg::*;

  initial begin
    if (LOCK_CYC < 1 || LOCK_CYC > 255) begin
      $error("LOCK_CYC must be 1 to 255");
    end
  end

  function automatic logic [1:0] bankOf(input logic [1:0] sel);
    bankOf = (sel == BANK_ALT) ? BANK_ALM : sel; // see [RULE_25]
  endfunction

  // falling (half=0) or rising (half=1) edge of the selected source clock; for the minute source the rising edge is the 1Hz one
  function automatic logic srcEdge(input logic [1:0] sel, input logic half,
                                   input logic [14:0] pc, input logic t32, input logic mt);
    case (sel) // see [RULE_15]
      SRC_4096: srcEdge = t32 && ((pc & DIV_4096) == (half ? HALF_4096 : DIV_4096));
      SRC_64: srcEdge = t32 && ((pc & DIV_64) == (half ? HALF_64 : DIV_64));
      SRC_1HZ: srcEdge = t32 && (pc == (half ? HALF_1HZ : DIV_1HZ));
      default: srcEdge = half ? (t32 && pc == HALF_1HZ) : mt;
    endcase
  endfunction

  function automatic logic [5:0] monthDays(input logic mT, input logic [3:0] mU,
                                           input logic leap);
    if (!mT && mU == DIG_TWO) begin
      monthDays = leap ? 6'h29 : 6'h28; // see [RULE_03]
    end else if ((!mT && (mU == 4'h4 || mU == 4'h6 || mU == 4'h9)) ||
                 (mT && mU == DIG_ONE)) begin
      monthDays = 6'h30;
    end else begin
      monthDays = 6'h31;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release and host port
  logic [1:0] rstSync_r;
  logic rstnInt;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstnInt = rstSync_r[1];

  logic wrPrev_r, wrPrev_nxt;
  logic [1:0] bankSel_r, bankSel_nxt;
  logic [1:0] testTemp_r, testTemp_nxt;
  logic [3:0] rd_r, rd_nxt;
  logic [3:0] alarm_r [ALARM_REGS];
  logic [3:0] alarm_nxt [ALARM_REGS];
  logic [3:0] preLo_r, preLo_nxt, preHi_r, preHi_nxt;
  logic [3:0] tset_r, tset_nxt;
  logic aie_r, aie_nxt, tie_r, tie_nxt;
  logic wrTake;
  logic [1:0] bank;
  logic [3:0] wa, wd;

  // weekday and calendar state
  logic [2:0] wday_r, wday_nxt;
  logic [3:0] dateU_r, dateU_nxt, monU_r, monU_nxt;
  logic [1:0] dateT_r, dateT_nxt, yearK_r, yearK_nxt;
  logic monT_r, monT_nxt;
  logic [3:0] yearU_r, yearU_nxt, yearT_r, yearT_nxt, yearH_r, yearH_nxt;

  // countdown and flag state
  rca_tmr_type tst_r, tst_nxt;
  logic [14:0] presc_r, presc_nxt;
  logic [7:0] count_r, count_nxt;
  logic run_r, run_nxt, startFlag_r, startFlag_nxt;
  logic af_r, af_nxt, tf_r, tf_nxt;
  logic [7:0] afLock_r, afLock_nxt, tfLock_r, tfLock_nxt;
  logic aOe_r, aOe_nxt, tOe_r, tOe_nxt;
  logic aPinN_r, aPinN_nxt, tPinN_r, tPinN_nxt;

  logic leap, lastDay, alarmMatch, srcFall, srcRise, dec, zeroEvt;
  logic [5:0] dim;

  assign wrTake = !wrPrev_r && host.host_write_strobe_n && !host.selN;
  assign bank = bankOf(bankSel_r);
  assign wa = host.addr;
  assign wd = host.data;

  always_comb begin
    wrPrev_nxt = host.host_write_strobe_n;
    bankSel_nxt = bankSel_r;
    testTemp_nxt = testTemp_r;
    preLo_nxt = preLo_r; // see [RULE_19]
    preHi_nxt = preHi_r;
    tset_nxt = tset_r;
    aie_nxt = aie_r;
    tie_nxt = tie_r;
    for (int i = 0; i < ALARM_REGS; i++) begin
      alarm_nxt[i] = alarm_r[i];
    end
    if (wrTake) begin
      if (wa == R_CTRL_F) begin
        bankSel_nxt = wd[3:2];
      end
      if (wa == R_CTRL_E) begin
        testTemp_nxt = wd[3:2];
      end
      if (bank == BANK_ALM && wa <= R_DATE_T) begin
        alarm_nxt[wa] = wd;
      end
      if (bank == BANK_ALM && wa == R_CTRL_E) begin
        aie_nxt = wd[IEN_BIT];
      end
      if (bank == BANK_TMR) begin
        case (wa) // live count nibbles have no write path, see [RULE_24]
          R_PRE_LO: preLo_nxt = wd;
          R_PRE_HI: preHi_nxt = wd;
          R_TSET: tset_nxt = wd;
          R_CTRL_E: tie_nxt = wd[IEN_BIT];
          default: tset_nxt = tset_r;
        endcase
      end
    end
    rd_nxt = 4'h0;
    if (wa == R_CTRL_F) begin
      rd_nxt = {bankSel_r, 2'h0};
    end else if (bank == BANK_CAL) begin
      case (wa) // see [RULE_26]
        R_SEC_U: rd_nxt = clockNow.secU;
        R_SEC_T: rd_nxt = {1'b0, clockNow.secT};
        R_MIN_U: rd_nxt = clockNow.minU;
        R_MIN_T: rd_nxt = {1'b0, clockNow.minT};
        R_HOUR_U: rd_nxt = clockNow.hourU;
        R_HOUR_T: rd_nxt = {2'h0, clockNow.hourT};
        R_WDAY: rd_nxt = {1'b0, wday_r};
        R_DATE_U: rd_nxt = dateU_r;
        R_DATE_T: rd_nxt = {2'h0, dateT_r};
        R_MON_U: rd_nxt = monU_r;
        R_MON_T: rd_nxt = {3'h0, monT_r};
        R_YEAR_U: rd_nxt = yearU_r;
        R_YEAR_T: rd_nxt = yearT_r;
        R_YEAR_H: rd_nxt = yearH_r;
        default: rd_nxt = {testTemp_r, yearK_r}; // see [RULE_02]
      endcase
    end else if (bank == BANK_ALM) begin
      if (wa <= R_DATE_T) begin
        rd_nxt = alarm_r[wa];
      end else if (wa == R_CTRL_E) begin
        rd_nxt = {testTemp_r, af_r, aie_r};
      end
    end else begin
      case (wa)
        R_PRE_LO: rd_nxt = preLo_r;
        R_PRE_HI: rd_nxt = preHi_r;
        R_LIVE_LO: rd_nxt = count_r[3:0]; // see [RULE_17]
        R_LIVE_HI: rd_nxt = count_r[7:4];
        R_TSET: rd_nxt = {run_r, tset_r[2:0]};
        R_CTRL_E: rd_nxt = {testTemp_r, tf_r, tie_r};
        default: rd_nxt = 4'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      wrPrev_r <= 1'b1;
      bankSel_r <= BANK_CAL;
      testTemp_r <= 2'h0;
      rd_r <= 4'h0;
      preLo_r <= 4'h0;
      preHi_r <= 4'h0;
      tset_r <= 4'h0;
      aie_r <= 1'b0;
      tie_r <= 1'b0;
      for (int i = 0; i < ALARM_REGS; i++) begin
        alarm_r[i] <= 4'h0;
      end
    end else begin
      wrPrev_r <= wrPrev_nxt;
      bankSel_r <= bankSel_nxt;
      testTemp_r <= testTemp_nxt;
      rd_r <= rd_nxt;
      preLo_r <= preLo_nxt;
      preHi_r <= preHi_nxt;
      tset_r <= tset_nxt;
      aie_r <= aie_nxt;
      tie_r <= tie_nxt;
      for (int i = 0; i < ALARM_REGS; i++) begin
        alarm_r[i] <= alarm_nxt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // calendar: a year is a multiple of four when tens even and units 0/4/8,
  // or tens odd and units 2/6; enough for the supported span
  assign leap = yearT_r[0] ? (yearU_r == 4'h2 || yearU_r == 4'h6) :
                (yearU_r == 4'h0 || yearU_r == 4'h4 || yearU_r == 4'h8); // see [RULE_03]
  assign dim = monthDays(monT_r, monU_r, leap);
  assign lastDay = ({dateT_r, dateU_r} == dim);

  always_comb begin
    wday_nxt = wday_r;
    dateU_nxt = dateU_r;
    dateT_nxt = dateT_r;
    monU_nxt = monU_r;
    monT_nxt = monT_r;
    yearU_nxt = yearU_r;
    yearT_nxt = yearT_r;
    yearH_nxt = yearH_r;
    yearK_nxt = yearK_r;
    if (dayCarry) begin
      wday_nxt = (wday_r >= WDAY_LAST) ? 3'h0 : wday_r + 3'h1; // see [RULE_01] [RULE_27]
      if (!lastDay) begin
        dateU_nxt = (dateU_r == DIG_NINE) ? 4'h0 : dateU_r + 4'h1;
        dateT_nxt = (dateU_r == DIG_NINE) ? dateT_r + 2'h1 : dateT_r;
      end else begin
        dateU_nxt = DIG_ONE;
        dateT_nxt = 2'h0;
        if (monT_r && monU_r == DIG_TWO) begin
          monT_nxt = 1'b0;
          monU_nxt = DIG_ONE;
          yearU_nxt = (yearU_r == DIG_NINE) ? 4'h0 : yearU_r + 4'h1; // see [RULE_02]
          if (yearU_r == DIG_NINE) begin
            yearT_nxt = (yearT_r == DIG_NINE) ? 4'h0 : yearT_r + 4'h1;
            if (yearT_r == DIG_NINE) begin
              yearH_nxt = (yearH_r == DIG_NINE) ? 4'h0 : yearH_r + 4'h1;
              yearK_nxt = (yearH_r == DIG_NINE) ? yearK_r + 2'h1 : yearK_r;
            end
          end
        end else begin
          monU_nxt = (monU_r == DIG_NINE) ? 4'h0 : monU_r + 4'h1;
          monT_nxt = (monU_r == DIG_NINE) ? 1'b1 : monT_r;
        end
      end
    end
    if (wrTake && bank == BANK_CAL) begin
      case (wa) // a host write wins over a same-cycle rollover
        R_WDAY: wday_nxt = wd[2:0];
        R_DATE_U: dateU_nxt = wd;
        R_DATE_T: dateT_nxt = wd[1:0];
        R_MON_U: monU_nxt = wd;
        R_MON_T: monT_nxt = wd[0];
        R_YEAR_U: yearU_nxt = wd;
        R_YEAR_T: yearT_nxt = wd;
        R_YEAR_H: yearH_nxt = wd;
        R_CTRL_E: yearK_nxt = wd[1:0];
        default: wday_nxt = wday_nxt;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      wday_r <= 3'h0;
      dateU_r <= DIG_ONE;
      dateT_r <= 2'h0;
      monU_r <= DIG_ONE;
      monT_r <= 1'b0;
      yearU_r <= 4'h0;
      yearT_r <= 4'h0;
      yearH_r <= 4'h0;
      yearK_r <= 2'h2;
    end else begin
      wday_r <= wday_nxt;
      dateU_r <= dateU_nxt;
      dateT_r <= dateT_nxt;
      monU_r <= monU_nxt;
      monT_r <= monT_nxt;
      yearU_r <= yearU_nxt;
      yearT_r <= yearT_nxt;
      yearH_r <= yearH_nxt;
      yearK_r <= yearK_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm compare, countdown and flags
  assign alarmMatch = // see [RULE_04] [RULE_07]
    (alarm_r[0] == clockNow.secU || alarm_r[1][MASK_BIT]) &&
    (alarm_r[1][2:0] == clockNow.secT || alarm_r[1][MASK_BIT]) &&
    (alarm_r[2] == clockNow.minU || alarm_r[3][MASK_BIT]) &&
    (alarm_r[3][2:0] == clockNow.minT || alarm_r[3][MASK_BIT]) &&
    (alarm_r[4] == clockNow.hourU || alarm_r[5][MASK_BIT]) &&
    (alarm_r[5][1:0] == clockNow.hourT || alarm_r[5][MASK_BIT]) &&
    (alarm_r[6][2:0] == wday_r || alarm_r[6][MASK_BIT]) &&
    (alarm_r[7] == dateU_r || alarm_r[8][MASK_BIT]) &&
    (alarm_r[8][1:0] == dateT_r || alarm_r[8][MASK_BIT]);

  assign srcFall = srcEdge(tset_r[1:0], 1'b0, presc_r, tick32k, minuteTick);
  assign srcRise = srcEdge(tset_r[1:0], 1'b1, presc_r, tick32k, minuteTick);
  // a stopped count at zero never decrements, so zero presets raise nothing
  assign dec = srcFall && count_r != 8'h0 &&
               (tst_r == TMR_RUN || tst_r == TMR_LAST); // see [RULE_20] [RULE_22]
  assign zeroEvt = dec && count_r == 8'h1;

  always_comb begin
    presc_nxt = tick32k ? presc_r + 15'h1 : presc_r;
    tst_nxt = tst_r;
    count_nxt = dec ? count_r - 8'h1 : count_r;
    run_nxt = run_r;
    startFlag_nxt = startFlag_r;
    if (tst_r == TMR_LAST && srcFall) begin
      tst_nxt = TMR_IDLE; // see [RULE_21]
    end
    if (zeroEvt) begin
      if (tset_r[MODE_BIT]) begin
        tst_nxt = TMR_RETURN; // see [RULE_13]
      end else if (!startFlag_r) begin
        run_nxt = 1'b0; // see [RULE_12]
        tst_nxt = TMR_IDLE;
      end
    end
    if (tst_r == TMR_RETURN && srcRise) begin
      count_nxt = {preHi_r, preLo_r}; // see [RULE_14] [RULE_23]
      tst_nxt = run_r ? TMR_RUN : TMR_IDLE;
    end
    if (wrTake && bank == BANK_TMR && wa == R_TSET) begin
      run_nxt = wd[RUN_BIT]; // see [RULE_08]
      if (wd[RUN_BIT] && tst_r == TMR_IDLE) begin
        tst_nxt = TMR_RUN;
        startFlag_nxt = tf_r;
      end else if (!wd[RUN_BIT] && tst_r == TMR_RUN) begin
        tst_nxt = TMR_LAST;
      end
    end
    if (wrTake && bank == BANK_TMR && (wa == R_PRE_LO || wa == R_PRE_HI)) begin
      count_nxt = {preHi_nxt, preLo_nxt}; // see [RULE_16] [RULE_18]
    end
    afLock_nxt = (afLock_r != 8'h0) ? afLock_r - 8'h1 : 8'h0;
    tfLock_nxt = (tfLock_r != 8'h0) ? tfLock_r - 8'h1 : 8'h0;
    af_nxt = af_r;
    tf_nxt = tf_r;
    if (wrTake && wa == R_CTRL_E && !wd[FLAG_BIT]) begin
      if (bank == BANK_ALM && afLock_r == 8'h0) begin
        af_nxt = 1'b0; // see [RULE_05]
      end
      if (bank == BANK_TMR && tfLock_r == 8'h0) begin
        tf_nxt = 1'b0; // see [RULE_09]
      end
    end
    // set after clear so an event in the clearing cycle is kept
    if (secTick && alarmMatch) begin
      af_nxt = 1'b1;
      afLock_nxt = 8'(LOCK_CYC);
    end
    if (zeroEvt) begin
      tf_nxt = 1'b1;
      tfLock_nxt = 8'(LOCK_CYC);
    end
    aOe_nxt = af_nxt && aie_nxt; // see [RULE_06]
    tOe_nxt = tie_nxt && // see [RULE_10] [RULE_11]
              (tset_nxt[MODE_BIT] ? (tst_nxt == TMR_RETURN) : tf_nxt);
    // pin values get flops of their own so no output leaves through a gate
    aPinN_nxt = !aOe_nxt;
    tPinN_nxt = !tOe_nxt;
  end

  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      presc_r <= 15'h0;
      tst_r <= TMR_IDLE;
      count_r <= 8'h0;
      run_r <= 1'b0;
      startFlag_r <= 1'b0;
      af_r <= 1'b0;
      tf_r <= 1'b0;
      afLock_r <= 8'h0;
      tfLock_r <= 8'h0;
      aOe_r <= 1'b0;
      tOe_r <= 1'b0;
      aPinN_r <= 1'b1;
      tPinN_r <= 1'b1;
    end else begin
      presc_r <= presc_nxt;
      tst_r <= tst_nxt;
      count_r <= count_nxt;
      run_r <= run_nxt;
      startFlag_r <= startFlag_nxt;
      af_r <= af_nxt;
      tf_r <= tf_nxt;
      afLock_r <= afLock_nxt;
      tfLock_r <= tfLock_nxt;
      aOe_r <= aOe_nxt;
      tOe_r <= tOe_nxt;
      aPinN_r <= aPinN_nxt;
      tPinN_r <= tPinN_nxt;
    end
  end

  assign hostRdData = rd_r;
  assign alarmIrqPinN = aPinN_r;
  assign alarmIrqPinNOe = aOe_r;
  assign countdownIrqPinN = tPinN_r;
  assign countdownIrqPinNOe = tOe_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstnInt);

  sequence s_zero_periodic;
    zeroEvt && tset_r[MODE_BIT];
  endsequence
  sequence s_return_done;
    tst_r == TMR_RETURN && srcRise;
  endsequence

  property p_wday_range;
    wday_r <= WDAY_LAST;
  endproperty
  a_wday_range: assert property (p_wday_range) else $error("bad weekday"); // see [RULE_01]
  property p_alarm_set;
    secTick && alarmMatch |=> af_r && afLock_r == 8'(LOCK_CYC);
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set"); // see [RULE_04]
  property p_af_hold;
    af_r && afLock_r != 8'h0 |=> af_r;
  endproperty
  a_af_hold: assert property (p_af_hold) else $error("alarm flag cleared early"); // see [RULE_05]
  property p_alarm_pin;
    af_r && aie_r |-> alarmIrqPinNOe && !alarmIrqPinN;
  endproperty
  a_alarm_pin: assert property (p_alarm_pin) else $error("alarm pin not driven"); // see [RULE_06]
  property p_tf_set;
    zeroEvt |=> tf_r && count_r == 8'h0 ##1 tf_r;
  endproperty
  a_tf_set: assert property (p_tf_set) else $error("countdown flag missing"); // see [RULE_09]
  property p_level_stop;
    zeroEvt && !tset_r[MODE_BIT] && !startFlag_r |=> !run_r && tst_r == TMR_IDLE;
  endproperty
  a_level_stop: assert property (p_level_stop) else $error("level stop failed"); // see [RULE_12]
  property p_periodic_pulse;
    s_zero_periodic ##1 tie_r |-> countdownIrqPinNOe;
  endproperty
  a_periodic_pulse: assert property (p_periodic_pulse) else $error("no pulse"); // see [RULE_13]
  property p_reload;
    s_return_done ##0 !wrTake |=> count_r == {preHi_r, preLo_r} && tst_r != TMR_RETURN;
  endproperty
  a_reload: assert property (p_reload) else $error("periodic reload failed"); // see [RULE_14]
  property p_preset_load;
    wrTake && bank == BANK_TMR && wa == R_PRE_LO |=> count_r[3:0] == $past(wd);
  endproperty
  a_preset_load: assert property (p_preset_load) else $error("preset not loaded"); // see [RULE_18]
endmodule

/* File: bench/rca_host_model.sv */
// host microcontroller model: strobed writes and addressed reads
module rca_host_model
  import rca_pkg::*;
(
  input wire logic clk_sys,
  output rca_host_type host,
  input wire logic [3:0] hostRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    host = '{selN: 1'b1, host_write_strobe_n: 1'b1, addr: 4'h0, data: 4'h0};
  end
  ////////////////////////////////////////////////////////////////////////////
  // strobe rises while select still low, so the write lands on that edge
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(negedge clk_sys);
    host = '{selN: 1'b0, host_write_strobe_n: 1'b0, addr: a, data: d};
    @(negedge clk_sys);
    host.host_write_strobe_n = 1'b1;
    @(negedge clk_sys);
    host.selN = 1'b1;
    host.data = ~d;
  endtask
  // read data trails the address by one cycle
  task automatic rd(input logic [3:0] a, output logic [3:0] d);
    @(negedge clk_sys);
    host.addr = a;
    @(negedge clk_sys);
    @(negedge clk_sys);
    d = hostRdData;
  endtask
endmodule

/* File: bench/rtc_calendar_alarm_timer_tb.sv */
// self-checking bench for the calendar, alarm and countdown block
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module rtc_calendar_alarm_timer_tb;
  import rca_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic tick32k = 1'b0;
  logic secTick = 1'b0;
  logic minuteTick = 1'b0;
  logic dayCarry = 1'b0;
  logic [1:0] tdiv = 2'h0;
  rca_clock_type clockNow = '0;
  rca_host_type host;
  logic [3:0] hostRdData;
  logic aOe, aPin, cOe, cPin;
  int n_mismatch = 0;
  int comparisons = 0;
  int yr, n;
  logic [3:0] v;
  always #4 clk_sys = ~clk_sys;
  // short tick period keeps the 4096 source at 32 cycles
  always @(negedge clk_sys) begin
    tdiv <= tdiv + 2'h1;
    tick32k <= (tdiv == 2'h3);
  end
  rca_top #(.LOCK_CYC(8)) rca_top_inst (.clk_sys(clk_sys), .rstn(rstn), .host(host),
    .tick32k(tick32k), .secTick(secTick), .minuteTick(minuteTick), .dayCarry(dayCarry),
    .clockNow(clockNow), .hostRdData(hostRdData), .alarmIrqPinN(aPin),
    .alarmIrqPinNOe(aOe), .countdownIrqPinN(cPin), .countdownIrqPinNOe(cOe));
  rca_host_model rca_host_model_inst (.clk_sys(clk_sys), .host(host),
    .hostRdData(hostRdData));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] dig(input int y, input int p);
    return 4'((y / p) % 10);
  endfunction
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    rca_host_model_inst.wr(a, d);
  endtask
  task automatic chk(input logic [3:0] a, input logic [3:0] e, input string nm);
    logic [3:0] d;
    rca_host_model_inst.rd(a, d);
    `CHK(nm, e, d)
  endtask
  task automatic pulse(input int k);
    @(negedge clk_sys);
    secTick = (k == 0);
    dayCarry = (k == 1);
    minuteTick = (k == 2);
    @(negedge clk_sys);
    {secTick, dayCarry, minuteTick} = 3'h0;
    @(negedge clk_sys);
  endtask
  task automatic wcd(input logic e, input int lim, input string nm);
    int i;
    i = 0;
    while (cOe !== e && i < lim) begin
      @(negedge clk_sys);
      i++;
    end
    `CHK(nm, e, cOe)
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #(40000 * 8);
    n_mismatch++;
    $display("watchdog expired");
    give_verdict;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h59CD));
    clockNow = '{secU: 4'($urandom_range(0, 9)), secT: 3'h2, minU: 4'h7,
                 minT: 3'h4, hourU: 4'h1, hourT: 2'h1};
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(R_WDAY, 4'h0, "wday");
    chk(R_CTRL_E, 4'h2, "yearth");
    wr(R_WDAY, 4'h6);
    pulse(1);
    chk(R_WDAY, 4'h0, "wdaywrap");
    // random year, Feb 28, one day carry
    yr = 1901 + $urandom_range(0, 198);
    wr(R_DATE_U, 4'h8);
    wr(R_DATE_T, 4'h2);
    wr(R_MON_U, 4'h2);
    wr(R_MON_T, 4'h0);
    wr(R_YEAR_U, dig(yr, 1));
    wr(R_YEAR_T, dig(yr, 10));
    wr(R_YEAR_H, dig(yr, 100));
    wr(R_CTRL_E, dig(yr, 1000));
    pulse(1);
    chk(R_DATE_U, (yr % 4 == 0) ? 4'h9 : 4'h1, "feb");
    chk(R_MON_U, (yr % 4 == 0) ? 4'h2 : 4'h3, "mon");
    chk(R_YEAR_H, dig(yr, 100), "yearh");
    $display("calendar test done");
    v = 4'($urandom_range(0, 15));
    wr(R_CTRL_F, {BANK_ALT, 2'h0});
    wr(R_SEC_U, v);
    chk(R_CTRL_F, {BANK_ALT, 2'h0}, "bankf");
    wr(R_CTRL_F, {BANK_ALM, 2'h0});
    chk(R_SEC_U, v, "bank3");
    // all fields masked except the minute
    for (int r = 1; r <= 8; r++) wr(4'(r), 4'h8);
    wr(R_MIN_U, (clockNow.minU == 4'h9) ? 4'h0 : clockNow.minU + 4'h1);
    wr(R_MIN_T, {1'b0, clockNow.minT});
    wr(R_CTRL_E, 4'h1);
    pulse(0);
    chk(R_CTRL_E, 4'h1, "nomatch");
    wr(R_MIN_U, clockNow.minU);
    pulse(0);
    `CHK("aoe", 1'b1, aOe)
    `CHK("apin", 1'b0, aPin)
    // clear lands inside the lockout window and must be ignored
    wr(R_CTRL_E, 4'h1);
    chk(R_CTRL_E, 4'h3, "alock");
    wr(R_CTRL_E, 4'h2);
    chk(R_CTRL_E, 4'h2, "aflag");
    `CHK("aoeoff", 1'b0, aOe)
    wr(R_CTRL_E, 4'h1);
    chk(R_CTRL_E, 4'h1, "aclr");
    $display("alarm test done");
    wr(R_CTRL_F, {BANK_TMR, 2'h0});
    chk(R_SEC_U, 4'h0, "b2r0");
    v = 4'($urandom_range(1, 15));
    wr(R_PRE_HI, v);
    chk(R_LIVE_HI, v, "livehi");
    chk(R_PRE_HI, v, "prehi");
    n = $urandom_range(1, 5);
    wr(R_PRE_HI, 4'h0);
    wr(R_PRE_LO, 4'(n));
    wr(R_LIVE_LO, 4'hF);
    chk(R_LIVE_LO, 4'(n), "livelo");
    wr(R_CTRL_E, 4'h1);
    wr(R_TSET, 4'h8);
    wcd(1'b1, 40 * (n + 2), "lvlirq");
    `CHK("cpin", 1'b0, cPin)
    chk(R_LIVE_LO, 4'h0, "zero");
    chk(R_TSET, 4'h0, "runclr");
    repeat (100) @(negedge clk_sys);
    `CHK("lvlhold", 1'b1, cOe)
    wr(R_CTRL_E, 4'h3);
    chk(R_CTRL_E, 4'h3, "tflag");
    wr(R_CTRL_E, 4'h1);
    wcd(1'b0, 4, "tclr");
    // level stop left the count at zero, which never decrements
    wr(R_PRE_LO, 4'(n));
    wr(R_TSET, 4'hC);
    wcd(1'b1, 40 * (n + 2), "perirq");
    wcd(1'b0, 20, "perret");
    chk(R_LIVE_LO, 4'(n), "reload");
    wcd(1'b1, 40 * (n + 1), "again");
    wr(R_TSET, 4'h0);
    repeat (40) @(negedge clk_sys);
    wr(R_CTRL_E, 4'h1);
    $display("timer test done");
    // two steps: 4096 would finish in 80 cycles, 64 cannot whatever its phase
    wr(R_PRE_LO, 4'h2);
    wr(R_TSET, 4'h9);
    repeat (80) @(negedge clk_sys);
    `CHK("src64", 1'b0, cOe)
    wcd(1'b1, 4400, "src64b");
    repeat (8) @(negedge clk_sys);
    wr(R_CTRL_E, 4'h1);
    wr(R_PRE_LO, 4'h1);
    wr(R_TSET, 4'hB);
    pulse(2);
    `CHK("srcmin", 1'b1, cOe)
    // restart with the flag still set: run bit must survive the zero
    wr(R_PRE_LO, 4'h1);
    wr(R_TSET, 4'hB);
    pulse(2);
    chk(R_TSET, 4'hB, "keeprun");
    $display("source test done");
    give_verdict;
  end
endmodule
